// ===== common/cpw_pkg.sv
// constants and register map of the compare, pulse and watchdog block
// Contract
// [R1] match sets flag, flag may request interrupt
// [R2] flag stays set until software clears it
// [R3] low byte write clears, high sets compare_enable
// [R4] software writes low byte before high byte
// [R5] high speed output toggles pin on match
// [R6] frequency mode toggles, adds high to low
// [R7] frequency is clock over twice high byte
// [R8] 8-bit pulse: high on match, low overflow
// [R9] 8-bit pulse reloads low from high byte
// [R10] 8-bit duty is (256 - high)/256
// [R11] cleared compare_enable gives constant low pulse
// [R12] 16-bit pulse: high on match, low overflow
// [R13] software updates 16-bit duty on match interrupts
// [R14] module 2 is watchdog when enabled
// [R15] watchdog freezes counter, timebase, idle, module 2
// [R16] watchdog forces counter on, counter_run reads own
// [R17] update write loads counter high plus offset
// [R18] low overflow on update match resets system
// [R19] writing one to module 2 flag forces reset
// [R20] lock keeps watchdog on until reset
// [R21] reset: watchdog on, divide 12, bytes zero
// [R22] software disables watchdog before reconfiguring it
// [R23] reset request is a registered pulse
package cpw_pkg;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] MODE_OFS = 8'h04;
   localparam logic [7:0] CNTL_OFS = 8'h08;
   localparam logic [7:0] CNTH_OFS = 8'h0c;
   localparam logic [7:0] CPM_BASE = 8'h10;
   localparam logic [7:0] CPL_BASE = 8'h20;
   localparam logic [7:0] CPH_BASE = 8'h24;
   localparam int CPM_STEP = 4;
   localparam int CP_STEP = 8;
   localparam int NUM_MOD = 3;
   localparam int WD_MOD = 2;
   localparam int CF_BIT = 7;
   localparam int CR_BIT = 6;
   localparam int IDLE_SUSPEND_BIT = 7;
   localparam int WATCHDOG_ENABLE_BIT = 6;
   localparam int WATCHDOG_LOCK_BIT = 5;
   localparam int CPS_LSB = 1;
   localparam int ECF_BIT = 0;
   localparam int PWM16_BIT = 7;
   localparam int ECOM_BIT = 6;
   localparam int MAT_BIT = 3;
   localparam int TOG_BIT = 2;
   localparam int PWM_BIT = 1;
   localparam int ECCF_BIT = 0;
   localparam logic [7:0] CPM_RST = 8'h00;
   localparam logic [7:0] CP_RST = 8'h00;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic WATCHDOG_ENABLE_RST = 1'b1;
   localparam logic [3:0] DIV12 = 4'hc;
   localparam logic [3:0] DIV4 = 4'h4;
   typedef enum logic [2:0] {
      CPS_DIV12 = 3'b000,
      CPS_DIV4 = 3'b001,
      CPS_T0 = 3'b010,
      CPS_ECI = 3'b011,
      CPS_SYS = 3'b100,
      CPS_EXT = 3'b101
   } cpw_cps_t;
endpackage : cpw_pkg

// ===== logic/cpw_top.sv
// compare, pulse width, frequency output and watchdog logic with an apb slave
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module cpw_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cpu_idle,
   input wire logic alt_tick,
   output logic [cpw_pkg::NUM_MOD-1:0] module_pin,
   output logic irq_req,
   output logic wd_reset_req
);
   import cpw_pkg::*;

   logic pready_reg, pslverr_reg, irq_reg, wd_rst_reg;
   logic [31:0] prdata_reg;
   logic cf_reg, cr_reg, idle_suspend_reg, watchdog_enable_reg, watchdog_lock_reg, ecf_reg;
   logic [2:0] cps_reg;
   logic [15:0] cnt_reg, cnt_next;
   logic [7:0] snap_reg;
   logic [3:0] div_reg, div_lim;
   logic [7:0] mode_reg [NUM_MOD];
   logic [7:0] cpl_reg [NUM_MOD];
   logic [7:0] cph_reg [NUM_MOD];
   logic ccf_reg [NUM_MOD];
   logic pin_reg [NUM_MOD];
   logic m16_s [NUM_MOD];
   logic wr_cpl_s [NUM_MOD];
   logic wr_cph_s [NUM_MOD];
   logic acc, wr, rd_first, wr_ctrl, wr_mode, wd_on, run, tick, lo_ovf, full_ovf, wd_hit;
   logic wd_force, hit;
   logic [7:0] rd_byte;

   // one wait state: the answer comes in the second access cycle
   assign acc = psel && penable;
   assign wr = acc && pready_reg && pwrite;
   assign rd_first = acc && !pready_reg && !pwrite;
   assign wr_ctrl = wr && paddr == CTRL_OFS;
   assign wr_mode = wr && paddr == MODE_OFS;
   assign wd_on = watchdog_enable_reg || watchdog_lock_reg; // [R20]

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq_req = irq_reg;
   assign wd_reset_req = wd_rst_reg;
   generate
      for (genvar p = 0; p < NUM_MOD; p++) begin : g_pin
         assign module_pin[p] = pin_reg[p];
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= acc && !pready_reg;
         if (acc && !pready_reg) begin
            prdata_reg <= {24'h00_0000, rd_byte};
            pslverr_reg <= !hit;
         end
      end
   end

   // timebase: the counter only advances, by one, in each cycle that tick is high
   assign run = (cr_reg || wd_on) && !(idle_suspend_reg && cpu_idle); // [R16]
   assign div_lim = (cps_reg == CPS_DIV4) ? DIV4 : DIV12;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg <= 4'h0;
      end else if (!run || div_reg == div_lim - 4'h1) begin
         div_reg <= 4'h0;
      end else begin
         div_reg <= div_reg + 4'h1;
      end
   end

   always_comb begin
      unique case (cps_reg)
         CPS_DIV12, CPS_DIV4: tick = run && div_reg == div_lim - 4'h1; // [R21]
         CPS_SYS: tick = run;
         CPS_T0, CPS_ECI, CPS_EXT: tick = run && alt_tick;
         default: tick = 1'b0;
      endcase
   end

   assign cnt_next = cnt_reg + 16'h0001;
   assign lo_ovf = tick && cnt_reg[7:0] == 8'hff;
   assign full_ovf = tick && cnt_reg == 16'hffff;

   // counting wins over a software load in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= CNT_RST; // [R21]
      end else if (tick) begin
         cnt_reg <= cnt_next;
      end else if (wr && !wd_on && paddr == CNTL_OFS) begin // [R15]
         cnt_reg[7:0] <= pwdata[7:0];
      end else if (wr && !wd_on && paddr == CNTH_OFS) begin // [R15]
         cnt_reg[15:8] <= pwdata[7:0];
      end
   end

   // reading the low byte freezes the high byte for a coherent 16-bit read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         snap_reg <= 8'h00;
      end else if (rd_first && paddr == CNTL_OFS) begin
         snap_reg <= cnt_reg[15:8];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cf_reg <= 1'b0;
         cr_reg <= 1'b0;
      end else begin
         if (full_ovf) begin
            cf_reg <= 1'b1;
         end else if (wr_ctrl) begin
            cf_reg <= pwdata[CF_BIT];
         end
         if (wr_ctrl) begin
            cr_reg <= pwdata[CR_BIT]; // [R16]
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_suspend_reg <= 1'b0;
         watchdog_enable_reg <= WATCHDOG_ENABLE_RST; // [R21]
         watchdog_lock_reg <= 1'b0;
         cps_reg <= CPS_DIV12; // [R21]
         ecf_reg <= 1'b0;
      end else if (wr_mode) begin
         // a locked watchdog keeps the enable bit of its locking write, so software sees it on only if that write set it
         watchdog_enable_reg <= watchdog_lock_reg ? watchdog_enable_reg : pwdata[WATCHDOG_ENABLE_BIT]; // [R20]
         watchdog_lock_reg <= watchdog_lock_reg || pwdata[WATCHDOG_LOCK_BIT]; // [R20]
         if (!wd_on) begin // [R15]
            idle_suspend_reg <= pwdata[IDLE_SUSPEND_BIT];
            cps_reg <= pwdata[CPS_LSB+:3];
            ecf_reg <= pwdata[ECF_BIT];
         end
      end
   end

   generate
      for (genvar g = 0; g < NUM_MOD; g++) begin : g_mod
         logic wd_mod, wr_cpm, ecom, mat, tog, pwm, wide, m8;
         assign wd_mod = (g == WD_MOD) && wd_on; // [R14]
         assign wr_cpm = wr && paddr == CPM_BASE + 8'(CPM_STEP * g);
         assign wr_cpl_s[g] = wr && paddr == CPL_BASE + 8'(CP_STEP * g);
         assign wr_cph_s[g] = wr && paddr == CPH_BASE + 8'(CP_STEP * g);
         assign ecom = mode_reg[g][ECOM_BIT];
         assign mat = mode_reg[g][MAT_BIT];
         assign tog = mode_reg[g][TOG_BIT];
         assign pwm = mode_reg[g][PWM_BIT];
         assign wide = mode_reg[g][PWM16_BIT];
         assign m16_s[g] = tick && ecom && !wd_mod && cnt_next == {cph_reg[g], cpl_reg[g]};
         assign m8 = tick && ecom && !wd_mod && cnt_next[7:0] == cpl_reg[g];

         // module 2 keeps its mode while the watchdog owns it
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               mode_reg[g] <= CPM_RST;
            end else if (wd_mod) begin // [R15]
               mode_reg[g] <= mode_reg[g];
            end else if (wr_cpm) begin
               mode_reg[g] <= pwdata[7:0];
            end else if (wr_cpl_s[g]) begin
               mode_reg[g][ECOM_BIT] <= 1'b0; // [R3]
            end else if (wr_cph_s[g]) begin
               mode_reg[g][ECOM_BIT] <= 1'b1; // [R3]
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cpl_reg[g] <= CP_RST; // [R21]
            end else if (wr_cpl_s[g]) begin
               cpl_reg[g] <= pwdata[7:0];
            end else if (!wd_mod && ecom && pwm && !tog && !wide && lo_ovf) begin
               cpl_reg[g] <= cph_reg[g]; // [R9]
            end else if (pwm && tog && m8) begin
               // a zero step wraps all 256 counts [R6] [R7]
               cpl_reg[g] <= cpl_reg[g] + cph_reg[g];
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cph_reg[g] <= CP_RST;
            end else if (wr_cph_s[g] && wd_mod) begin
               cph_reg[g] <= cnt_reg[15:8] + cpl_reg[g]; // [R17]
            end else if (wr_cph_s[g]) begin
               cph_reg[g] <= pwdata[7:0];
            end
         end

         // hardware set wins over a software clear in the same cycle
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ccf_reg[g] <= 1'b0;
            end else if (m16_s[g] && mat) begin
               ccf_reg[g] <= 1'b1; // [R1]
            end else if (wr_ctrl) begin
               ccf_reg[g] <= pwdata[g]; // [R2]
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_reg[g] <= 1'b0;
            end else if (wd_mod) begin
               pin_reg[g] <= pin_reg[g];
            end else if (pwm && !tog) begin
               if (!ecom) begin
                  pin_reg[g] <= 1'b0; // [R11]
               end else if (wide && full_ovf) begin
                  pin_reg[g] <= {cph_reg[g], cpl_reg[g]} == 16'h0000; // [R12]
               end else if (wide && m16_s[g]) begin
                  pin_reg[g] <= 1'b1; // [R12]
               end else if (!wide && lo_ovf) begin
                  pin_reg[g] <= cph_reg[g] == 8'h00; // [R8] [R10]
               end else if (!wide && m8) begin
                  pin_reg[g] <= 1'b1; // [R8]
               end
            end else if (tog && pwm && m8) begin
               pin_reg[g] <= !pin_reg[g]; // [R6]
            end else if (tog && mat && m16_s[g]) begin
               pin_reg[g] <= !pin_reg[g]; // [R5]
            end
         end
      end
   endgenerate

   // the high byte is compared before the carry from the low byte lands
   assign wd_hit = wd_on && lo_ovf && cph_reg[WD_MOD] == cnt_reg[15:8]; // [R18]
   assign wd_force = wr_ctrl && pwdata[WD_MOD] && wd_on; // [R19]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_rst_reg <= 1'b0;
      end else begin
         wd_rst_reg <= wd_hit || wd_force; // [R23]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= (cf_reg && ecf_reg) || (ccf_reg[0] && mode_reg[0][ECCF_BIT]) ||
                    (ccf_reg[1] && mode_reg[1][ECCF_BIT]) ||
                    (ccf_reg[2] && mode_reg[2][ECCF_BIT]); // [R1]
      end
   end

   always_comb begin
      hit = 1'b1;
      rd_byte = 8'h00;
      if (paddr == CTRL_OFS) begin
         rd_byte = {cf_reg, cr_reg, 3'b000, ccf_reg[2], ccf_reg[1], ccf_reg[0]}; // [R16]
      end else if (paddr == MODE_OFS) begin
         rd_byte = {idle_suspend_reg, watchdog_enable_reg, watchdog_lock_reg, 1'b0, cps_reg, ecf_reg};
      end else if (paddr == CNTL_OFS) begin
         rd_byte = cnt_reg[7:0];
      end else if (paddr == CNTH_OFS) begin
         rd_byte = snap_reg;
      end else begin
         hit = 1'b0;
         for (int i = 0; i < NUM_MOD; i++) begin
            if (paddr == CPM_BASE + 8'(CPM_STEP * i)) begin
               rd_byte = mode_reg[i];
               hit = 1'b1;
            end
            if (paddr == CPL_BASE + 8'(CP_STEP * i)) begin
               rd_byte = cpl_reg[i];
               hit = 1'b1;
            end
            if (paddr == CPH_BASE + 8'(CP_STEP * i)) begin
               rd_byte = cph_reg[i];
               hit = 1'b1;
            end
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_ecom_low_clear: assert property (wr_cpl_s[0] |=> !mode_reg[0][ECOM_BIT]) // [R3]
      else $error("low byte write left compare enabled");
   a_ecom_high_set: assert property (wr_cph_s[0] |=> mode_reg[0][ECOM_BIT]) // [R3]
      else $error("high byte write did not enable compare");
   a_flag_set: assert property (m16_s[0] && mode_reg[0][MAT_BIT] |=> ccf_reg[0]) // [R1]
      else $error("match did not set flag");
   a_flag_held: assert property (ccf_reg[1] && !wr_ctrl |=> ccf_reg[1]) // [R2]
      else $error("flag cleared without software write");
   a_hso_toggle: assert property (m16_s[1] && mode_reg[1][TOG_BIT] && mode_reg[1][MAT_BIT] &&
      !mode_reg[1][PWM_BIT] |=> pin_reg[1] != $past(pin_reg[1])) // [R5]
      else $error("high speed output did not toggle");
   a_pwm_zero: assert property (mode_reg[0][PWM_BIT] && !mode_reg[0][TOG_BIT] &&
      !mode_reg[0][ECOM_BIT] |=> !pin_reg[0]) // [R11]
      else $error("pulse output not low with compare off");
   a_cnt_locked: assert property (wd_on && !tick |=> cnt_reg == $past(cnt_reg)) // [R15]
      else $error("counter changed while watchdog on");
   a_wd_reload: assert property (wd_on && wr_cph_s[WD_MOD] |=>
      cph_reg[WD_MOD] == $past(cnt_reg[15:8]) + $past(cpl_reg[WD_MOD])) // [R17]
      else $error("watchdog reload value wrong");
   a_wd_expire: assert property (wd_hit |=> wd_reset_req) // [R18]
      else $error("watchdog expiry gave no reset");
   a_force_reset: assert property (wd_force |=> wd_reset_req ##1 !wd_reset_req || wd_hit) // [R19]
      else $error("forced watchdog reset missing");
   a_wd_lock: assert property (watchdog_lock_reg |=> watchdog_lock_reg && wd_on) // [R20]
      else $error("locked watchdog turned off");
   a_tick_div12: assert property (tick && cps_reg == CPS_DIV12 && !cpu_idle
      |=> !tick [*8]) // [R21]
      else $error("divide by 12 ticks too close");

   c_wd_reset: cover property (wd_hit);
   c_freq_toggle: cover property (mode_reg[1][TOG_BIT] && mode_reg[1][PWM_BIT] && g_mod[1].m8);
   c_pwm16_high: cover property (mode_reg[1][PWM16_BIT] && m16_s[1]);
   c_flag_set: cover property ($rose(ccf_reg[0]));
endmodule : cpw_top
`default_nettype wire

// ===== verification/cpw_pin_monitor.sv
// pin-side model: counts high samples and level changes of one module pin
`timescale 1ns/1ns
`default_nettype none
module cpw_pin_monitor (
   input wire logic pclk,
   input wire logic clr,
   input wire logic [2:0] pins,
   input wire logic [1:0] sel,
   output logic [15:0] high_cnt,
   output logic [15:0] edge_cnt
);
   logic last;
   // a window covering whole periods gives exact counts whatever its phase
   always_ff @(posedge pclk) begin
      last <= pins[sel];
      if (clr) begin
         high_cnt <= '0;
         edge_cnt <= '0;
      end else begin
         high_cnt <= high_cnt + 16'(pins[sel]);
         edge_cnt <= edge_cnt + 16'(pins[sel] != last);
      end
   end
endmodule : cpw_pin_monitor
`default_nettype wire

// ===== verification/compare_pwm_watchdog_bench.sv
// self-checking bench for the compare, pulse and watchdog block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; \
   $display("ERROR %0t: got %h want %h", $time, a, e); end end
module compare_pwm_watchdog_bench;
   import cpw_pkg::*;
   typedef struct {logic [7:0] wa; logic [7:0] wd; logic [7:0] ra; logic [7:0] exp;} cpw_row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_req, wd_reset_req;
   logic cpu_idle, alt_tick, mon_clr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] module_pin;
   logic [1:0] mon_sel;
   logic [15:0] high_cnt, edge_cnt;
   int errors, tests_run, n;
   cpw_row_t rows [10] = '{
      '{MODE_OFS, 8'h00, MODE_OFS, 8'h00},
      '{CTRL_OFS, 8'h00, CTRL_OFS, 8'h00},
      '{CNTH_OFS, 8'h00, CNTL_OFS, 8'h00},
      '{CNTL_OFS, 8'h00, CNTH_OFS, 8'h00},
      '{MODE_OFS, 8'h08, MODE_OFS, 8'h08},
      '{CPM_BASE, 8'h49, CPM_BASE, 8'h49},
      '{CPL_BASE, 8'h05, CPM_BASE, 8'h09},
      '{CPH_BASE, 8'h00, CPM_BASE, 8'h49},
      '{CPL_BASE + 8'h08, 8'h08, CPM_BASE + 8'h04, 8'h00},
      '{CPH_BASE + 8'h08, 8'h00, CPM_BASE + 8'h04, 8'h40}
   };

   cpw_top u_cpw_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cpu_idle(cpu_idle), .alt_tick(alt_tick), .module_pin(module_pin),
      .irq_req(irq_req), .wd_reset_req(wd_reset_req));
   cpw_pin_monitor u_cpw_pin_monitor (.pclk(pclk), .clr(mon_clr), .pins(module_pin),
      .sel(mon_sel), .high_cnt(high_cnt), .edge_cnt(edge_cnt));

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   task automatic test_done;
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : test_done

   // called just after a rising edge; holds the request until pready is sampled
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      if (k >= 20) begin
         errors++;
         $display("ERROR %0t: no pready", $time);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic measure(input logic [1:0] s);
      mon_sel <= s;
      mon_clr <= 1'b1;
      @(posedge pclk);
      mon_clr <= 1'b0;
      repeat (513) @(posedge pclk);
   endtask : measure

   task automatic wait_wd(input int lim);
      n = 0;
      while (wd_reset_req !== 1'b1 && n < lim) begin
         @(posedge pclk);
         n++;
      end
   endtask : wait_wd

   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      $display("ERROR %0t: run timed out", $time);
      test_done();
   end

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, cpu_idle, alt_tick, mon_clr} = '0;
      paddr = '0;
      pwdata = '0;
      mon_sel = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].wa, rows[i].wd);
         apb(1'b0, rows[i].ra, 8'h00);
         `CHK(rd[7:0], rows[i].exp)
      end
      apb(1'b1, CPM_BASE + 8'h04, 8'h4c);
      apb(1'b0, 8'hfc, 8'h00);
      `CHK(err, 1'b1)
      // counter starts at zero, one tick per clock: flag at 5, pin 1 toggles at 8
      apb(1'b1, CTRL_OFS, 8'h40);
      repeat (20) @(posedge pclk);
      `CHK(irq_req, 1'b1)
      `CHK(module_pin[1], 1'b1)
      repeat (50) @(posedge pclk);
      apb(1'b0, CTRL_OFS, 8'h00);
      `CHK(rd[7:0], 8'h43)
      apb(1'b1, CTRL_OFS, 8'h40);
      apb(1'b0, CTRL_OFS, 8'h00);
      `CHK(rd[7:0], 8'h40)
      `CHK(irq_req, 1'b0)
      apb(1'b1, CPL_BASE, 8'hc0);
      apb(1'b1, CPH_BASE, 8'hc0);
      apb(1'b1, CPM_BASE, 8'h42);
      repeat (300) @(posedge pclk);
      measure(2'd0);
      `CHK(high_cnt, 16'd128)
      apb(1'b1, CPL_BASE, 8'h00);
      repeat (300) @(posedge pclk);
      measure(2'd0);
      `CHK(high_cnt, 16'd0)
      apb(1'b1, CPH_BASE, 8'h00);
      repeat (300) @(posedge pclk);
      measure(2'd0);
      `CHK(high_cnt, 16'd512)
      apb(1'b1, CPH_BASE + 8'h08, 8'h10);
      apb(1'b1, CPM_BASE + 8'h04, 8'h46);
      repeat (300) @(posedge pclk);
      measure(2'd1);
      `CHK(edge_cnt, 16'd32)
      apb(1'b1, CPH_BASE + 8'h08, 8'h00);
      repeat (600) @(posedge pclk);
      measure(2'd1);
      `CHK(edge_cnt, 16'd2)
      // 16-bit pulse on module 0: counter parked near the top, compare at 0x0040
      apb(1'b1, CTRL_OFS, 8'h00);
      apb(1'b1, CNTL_OFS, 8'hf0);
      apb(1'b1, CNTH_OFS, 8'hff);
      apb(1'b1, CPL_BASE, 8'h40);
      apb(1'b1, CPH_BASE, 8'h00);
      apb(1'b1, CPM_BASE, 8'hcb);
      apb(1'b1, CTRL_OFS, 8'h40);
      repeat (40) @(posedge pclk);
      `CHK(module_pin[0], 1'b0)
      `CHK(irq_req, 1'b0)
      repeat (80) @(posedge pclk);
      `CHK(module_pin[0], 1'b1)
      `CHK(irq_req, 1'b1)
      // watchdog set up in the documented order, offset of one high-byte step
      apb(1'b1, CPL_BASE + 8'h10, 8'h01);
      apb(1'b1, MODE_OFS, 8'h48);
      apb(1'b1, CPH_BASE + 8'h10, 8'hff);
      wait_wd(2000);
      `CHK(n > 250 && n < 520, 1'b1)
      @(posedge pclk);
      `CHK(wd_reset_req, 1'b0)
      apb(1'b1, CTRL_OFS, 8'h44);
      wait_wd(6);
      `CHK(wd_reset_req, 1'b1)
      apb(1'b1, MODE_OFS, 8'h68);
      apb(1'b1, MODE_OFS, 8'h00);
      apb(1'b0, MODE_OFS, 8'h00);
      `CHK(rd[7:0], 8'h68)
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      wait_wd(4000);
      `CHK(n > 3060 && n < 3090, 1'b1)
      apb(1'b0, MODE_OFS, 8'h00);
      `CHK(rd[7:0], 8'h40)
      apb(1'b0, CTRL_OFS, 8'h00);
      `CHK(rd[7:0], 8'h00)
      apb(1'b0, CPL_BASE + 8'h10, 8'h00);
      `CHK(rd[7:0], 8'h00)
      test_done();
   end
endmodule : compare_pwm_watchdog_bench
`default_nettype wire
